// ---- include/exec_pkg.sv ----
package exec_pkg;

  localparam int unsigned XLEN = 64;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned IMM_ZERO_W = 48;

  // Primary opcode field values.
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_REGIMM = 6'h01;
  localparam logic [5:0] OP_BR_EQ = 6'h04;
  localparam logic [5:0] OP_BR_NE = 6'h05;
  localparam logic [5:0] OP_BR_LEZ = 6'h06;
  localparam logic [5:0] OP_BR_GTZ = 6'h07;
  localparam logic [5:0] OP_ADD_IMM = 6'h08;
  localparam logic [5:0] OP_ADD_IMM_U = 6'h09;
  localparam logic [5:0] OP_AND_IMM = 6'h0C;
  localparam logic [5:0] OP_COP2 = 6'h12;
  localparam logic [5:0] OP_BR_EQ_L = 6'h14;
  localparam logic [5:0] OP_BR_NE_L = 6'h15;
  localparam logic [5:0] OP_BR_LEZ_L = 6'h16;
  localparam logic [5:0] OP_BR_GTZ_L = 6'h17;

  // Function field values under OP_SPECIAL.
  localparam logic [5:0] FN_ADD = 6'h20;
  localparam logic [5:0] FN_ADD_U = 6'h21;
  localparam logic [5:0] FN_AND = 6'h24;

  // Coprocessor 2 sub-operation in the first source field.
  localparam logic [4:0] CP_READ_CTRL = 5'h02;
  localparam logic [4:0] CP_WRITE_CTRL = 5'h06;
  localparam logic [4:0] CP_BRANCH = 5'h08;

  localparam logic [4:0] LINK_REG = 5'h1F;
  localparam logic [XLEN-1:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
  localparam logic [XLEN-1:0] SLOT_OFFSET = 64'h0000_0000_0000_0004;
  localparam logic [XLEN-1:0] RESET_DATA = 64'h0000_0000_0000_0000;
  localparam logic [4:0] RESET_INDEX = 5'h00;

  typedef enum logic [2:0] {
    COND_EQ,
    COND_NE,
    COND_GEZ,
    COND_GTZ,
    COND_LEZ,
    COND_LTZ,
    COND_COP_FALSE,
    COND_COP_TRUE
  } branch_cond_t;

endpackage

// ---- include/branch_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface branch_if;
  import exec_pkg::*;
  logic [XLEN-1:0] first_val;
  logic [XLEN-1:0] second_val;
  logic            cop_bit;
  branch_cond_t    cond;
  logic            taken;
  modport decoder (output first_val, output second_val, output cop_bit, output cond,
                   input taken);
  modport evaluator (input first_val, input second_val, input cop_bit, input cond,
                     output taken);
endinterface
`default_nettype wire

// ---- design/branch_eval.sv ----
`timescale 1ns/1ns
`default_nettype none
module branch_eval
  import exec_pkg::*;
(
  branch_if.evaluator bus
);

  logic is_neg;
  logic is_zero;

  assign is_neg = bus.first_val[XLEN-1];
  assign is_zero = (bus.first_val == RESET_DATA);

  always_comb begin
    unique case (bus.cond)
      COND_EQ:        bus.taken = (bus.first_val == bus.second_val); // [RULE5]
      COND_NE:        bus.taken = (bus.first_val != bus.second_val); // [RULE5]
      COND_GEZ:       bus.taken = !is_neg; // [RULE6]
      COND_GTZ:       bus.taken = !is_neg && !is_zero; // [RULE7]
      COND_LEZ:       bus.taken = is_neg || is_zero; // [RULE8]
      COND_LTZ:       bus.taken = is_neg; // [RULE9]
      COND_COP_FALSE: bus.taken = !bus.cop_bit; // [RULE3]
      COND_COP_TRUE:  bus.taken = bus.cop_bit; // [RULE3]
    endcase
  end

endmodule // branch_eval
`default_nettype wire

// ---- design/int_exec.sv ----
// Operation
// RULE1: Register and immediate add write source plus operand to destination.
// RULE2: AND-immediate zero-extends immediate to 64 bits; register AND uses both sources.
// RULE3: Coprocessor supplies condition bit; false forms branch on 0, true on 1.
// RULE4: Likely branches not taken suppress the following instruction.
// RULE5: Equal branch on equal sources, not-equal branch on differing sources.
// RULE6: Nonnegative branches taken when sign bit 63 is clear.
// RULE7: Positive branches taken when sign bit clear and value nonzero.
// RULE8: Nonpositive branches taken when sign bit set or value zero.
// RULE9: Negative branches taken when sign bit set; likely form nullifies.
// RULE10: Link branches write program counter plus 8 into register 31.
// RULE11: Move general register to coprocessor control register and back.
// RULE12: Signed adds trap on overflow, leaving destination; unsigned never trap.
`timescale 1ns/1ns
`default_nettype none
module int_exec
  import exec_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic            instr_valid,
  input  wire logic [31:0]     instr,
  input  wire logic [XLEN-1:0] pc,
  input  wire logic [XLEN-1:0] first_source_reg,
  input  wire logic [XLEN-1:0] second_source_reg,
  input  wire logic            cop_condition_bit,
  input  wire logic [XLEN-1:0] cop_ctrl_rdata,
  output logic [4:0]           cop_ctrl_rindex,
  output logic                 wb_valid,
  output logic [4:0]           wb_index,
  output logic [XLEN-1:0]      wb_data,
  output logic                 redirect_valid,
  output logic [XLEN-1:0]      redirect_pc,
  output logic                 nullify_next,
  output logic                 overflow_trap,
  output logic                 unknown_instr,
  output logic                 cop_ctrl_wr,
  output logic [4:0]           cop_ctrl_windex,
  output logic [XLEN-1:0]      cop_ctrl_wdata
);

  branch_if br ();

  branch_eval branch_eval_inst (
    .bus (br.evaluator)
  );

  logic [5:0]      op;
  logic [5:0]      fn;
  logic [4:0]      src1_f;
  logic [4:0]      src2_f;
  logic [4:0]      rd_f;
  logic [XLEN-1:0] imm_sext;
  logic [XLEN-1:0] imm_zext;
  logic [XLEN-1:0] br_target;
  logic [31:0]     add_b;
  logic [31:0]     sum32;
  logic            ovf32;
  logic [XLEN-1:0] sum_ext;
  logic            act;

  logic            wb_valid_ff, nxt_wb_valid;
  logic [4:0]      wb_index_ff, nxt_wb_index;
  logic [XLEN-1:0] wb_data_ff, nxt_wb_data;
  logic            redir_ff, nxt_redir;
  logic [XLEN-1:0] redir_pc_ff, nxt_redir_pc;
  logic            null_ff, nxt_null;
  logic            skip_ff, nxt_skip;
  logic            ovf_ff, nxt_ovf;
  logic            unk_ff, nxt_unk;
  logic            cwr_ff, nxt_cwr;
  logic [4:0]      cidx_ff, nxt_cidx;
  logic [XLEN-1:0] cdat_ff, nxt_cdat;

  assign op = instr[31:26];
  assign src1_f = instr[25:21];
  assign src2_f = instr[20:16];
  assign rd_f = instr[15:11];
  assign fn = instr[5:0];
  assign imm_sext = {{IMM_ZERO_W{instr[IMM_W-1]}}, instr[IMM_W-1:0]};
  assign imm_zext = {{IMM_ZERO_W{1'b0}}, instr[IMM_W-1:0]}; // [RULE2]
  assign br_target = pc + SLOT_OFFSET + {imm_sext[XLEN-3:0], 2'b00};
  assign add_b = (op == OP_SPECIAL) ? second_source_reg[31:0] : imm_sext[31:0];
  assign sum32 = first_source_reg[31:0] + add_b; // [RULE1]
  assign ovf32 = (first_source_reg[31] == add_b[31]) && (sum32[31] != add_b[31]);
  assign sum_ext = {{32{sum32[31]}}, sum32};
  assign act = instr_valid && !skip_ff;
  assign cop_ctrl_rindex = rd_f; // [RULE11]

  assign br.first_val = first_source_reg;
  assign br.second_val = second_source_reg;
  assign br.cop_bit = cop_condition_bit;

  always_comb begin
    unique case (op)
      OP_BR_EQ, OP_BR_EQ_L:   br.cond = COND_EQ; // [RULE5]
      OP_BR_NE, OP_BR_NE_L:   br.cond = COND_NE; // [RULE5]
      OP_BR_LEZ, OP_BR_LEZ_L: br.cond = COND_LEZ; // [RULE8]
      OP_BR_GTZ, OP_BR_GTZ_L: br.cond = COND_GTZ; // [RULE7]
      OP_REGIMM:              br.cond = src2_f[0] ? COND_GEZ : COND_LTZ; // [RULE6] [RULE9]
      OP_COP2:                br.cond = src2_f[0] ? COND_COP_TRUE : COND_COP_FALSE; // [RULE3]
      default:                br.cond = COND_EQ;
    endcase
  end

  always_comb begin
    nxt_wb_valid = 1'b0;
    nxt_wb_index = wb_index_ff;
    nxt_wb_data = wb_data_ff;
    nxt_redir = 1'b0;
    nxt_redir_pc = redir_pc_ff;
    nxt_null = 1'b0;
    nxt_skip = skip_ff && !instr_valid; // [RULE4]
    nxt_ovf = 1'b0;
    nxt_unk = 1'b0;
    nxt_cwr = 1'b0;
    nxt_cidx = cidx_ff;
    nxt_cdat = cdat_ff;
    if (act) begin
      unique case (op)
        OP_SPECIAL: begin
          if (fn == FN_ADD || fn == FN_ADD_U) begin
            nxt_wb_index = rd_f;
            nxt_wb_data = sum_ext; // [RULE1]
            nxt_ovf = (fn == FN_ADD) && ovf32; // [RULE12]
            nxt_wb_valid = !nxt_ovf; // [RULE12]
          end else if (fn == FN_AND) begin
            nxt_wb_valid = 1'b1;
            nxt_wb_index = rd_f;
            nxt_wb_data = first_source_reg & second_source_reg; // [RULE2]
          end else begin
            nxt_unk = 1'b1;
          end
        end
        OP_ADD_IMM, OP_ADD_IMM_U: begin
          nxt_wb_index = src2_f;
          nxt_wb_data = sum_ext; // [RULE1]
          nxt_ovf = (op == OP_ADD_IMM) && ovf32; // [RULE12]
          nxt_wb_valid = !nxt_ovf; // [RULE12]
        end
        OP_AND_IMM: begin
          nxt_wb_valid = 1'b1;
          nxt_wb_index = src2_f;
          nxt_wb_data = first_source_reg & imm_zext; // [RULE2]
        end
        OP_BR_EQ, OP_BR_EQ_L, OP_BR_NE, OP_BR_NE_L, OP_BR_LEZ, OP_BR_LEZ_L,
        OP_BR_GTZ, OP_BR_GTZ_L, OP_REGIMM, OP_COP2: begin
          if (op == OP_COP2 && src1_f == CP_READ_CTRL) begin
            nxt_wb_valid = 1'b1;
            nxt_wb_index = src2_f;
            nxt_wb_data = cop_ctrl_rdata; // [RULE11]
          end else if (op == OP_COP2 && src1_f == CP_WRITE_CTRL) begin
            nxt_cwr = 1'b1;
            nxt_cidx = rd_f;
            nxt_cdat = second_source_reg; // [RULE11]
          end else if ((op == OP_COP2 && src1_f != CP_BRANCH) ||
                       (op == OP_REGIMM && src2_f[3:2] != 2'b00)) begin
            nxt_unk = 1'b1;
          end else begin
            nxt_redir = br.taken;
            nxt_redir_pc = br_target; // [RULE3] [RULE5]
            if (op == OP_REGIMM && src2_f[4]) begin
              nxt_wb_valid = 1'b1;
              nxt_wb_index = LINK_REG;
              nxt_wb_data = pc + LINK_OFFSET; // [RULE10]
            end
            if (((op[4] && op != OP_COP2) || ((op == OP_REGIMM || op == OP_COP2) && src2_f[1]))
                && !br.taken) begin
              nxt_null = 1'b1;
              nxt_skip = 1'b1; // [RULE4]
            end
          end
        end
        default: nxt_unk = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_valid_ff <= 1'b0;
      wb_index_ff <= RESET_INDEX;
      wb_data_ff <= RESET_DATA;
      redir_ff <= 1'b0;
      redir_pc_ff <= RESET_DATA;
      null_ff <= 1'b0;
      skip_ff <= 1'b0;
      ovf_ff <= 1'b0;
      unk_ff <= 1'b0;
      cwr_ff <= 1'b0;
      cidx_ff <= RESET_INDEX;
      cdat_ff <= RESET_DATA;
    end else if (ce) begin
      wb_valid_ff <= nxt_wb_valid;
      wb_index_ff <= nxt_wb_index;
      wb_data_ff <= nxt_wb_data;
      redir_ff <= nxt_redir;
      redir_pc_ff <= nxt_redir_pc;
      null_ff <= nxt_null;
      skip_ff <= nxt_skip;
      ovf_ff <= nxt_ovf;
      unk_ff <= nxt_unk;
      cwr_ff <= nxt_cwr;
      cidx_ff <= nxt_cidx;
      cdat_ff <= nxt_cdat;
    end
  end

  assign wb_valid = wb_valid_ff;
  assign wb_index = wb_index_ff;
  assign wb_data = wb_data_ff;
  assign redirect_valid = redir_ff;
  assign redirect_pc = redir_pc_ff;
  assign nullify_next = null_ff;
  assign overflow_trap = ovf_ff;
  assign unknown_instr = unk_ff;
  assign cop_ctrl_wr = cwr_ff;
  assign cop_ctrl_windex = cidx_ff;
  assign cop_ctrl_wdata = cdat_ff;

endmodule // int_exec
`default_nettype wire

// ---- verif/int_exec_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module int_exec_properties
  import exec_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            ce,
  input wire logic            instr_valid,
  input wire logic [31:0]     instr,
  input wire logic [XLEN-1:0] pc,
  input wire logic [XLEN-1:0] first_source_reg,
  input wire logic [XLEN-1:0] second_source_reg,
  input wire logic            cop_condition_bit,
  input wire logic            wb_valid,
  input wire logic [4:0]      wb_index,
  input wire logic [XLEN-1:0] wb_data,
  input wire logic            redirect_valid,
  input wire logic            nullify_next,
  input wire logic            cop_ctrl_wr,
  input wire logic [4:0]      cop_ctrl_windex,
  input wire logic [XLEN-1:0] cop_ctrl_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic       acc = ce && instr_valid && !nullify_next;
  wire logic [5:0] op  = instr[31:26];
  a_link_ra: assert property (acc && op == OP_REGIMM && instr[20] |=> wb_valid
    && wb_index == LINK_REG && wb_data == $past(pc) + LINK_OFFSET) else $error("link bad");
  a_and_imm: assert property (acc && op == OP_AND_IMM |=> wb_valid
    && wb_data == ($past(first_source_reg) & {48'h0, $past(instr[15:0])}))
    else $error("and immediate bad");
  a_eq_branch: assert property (acc && (op == OP_BR_EQ || op == OP_BR_NE) |=>
    redirect_valid == (($past(first_source_reg) == $past(second_source_reg)) ^ $past(instr[26])))
    else $error("eq branch bad");
  a_lez_likely: assert property (acc && op == OP_BR_LEZ_L |=>
    nullify_next != redirect_valid
    && redirect_valid == ($past(first_source_reg[63]) || $past(first_source_reg) == 64'h0))
    else $error("lez likely bad");
  a_slot_drop: assert property (nullify_next && ce |=> !wb_valid && !redirect_valid
    && !cop_ctrl_wr && !nullify_next) else $error("slot not dropped");
  a_sign_branch: assert property (acc && op == OP_REGIMM |=> redirect_valid ==
    ($past(first_source_reg[63]) ^ $past(instr[16]))) else $error("sign branch bad");
  a_cop_write: assert property (acc && op == OP_COP2 && instr[25:21] == CP_WRITE_CTRL |=>
    cop_ctrl_wr && cop_ctrl_windex == $past(instr[15:11])
    && cop_ctrl_wdata == $past(second_source_reg)) else $error("cop write bad");
  a_cop_branch: assert property (acc && op == OP_COP2 && instr[25:21] == CP_BRANCH |=>
    redirect_valid == ($past(cop_condition_bit) == $past(instr[16]))) else $error("cop br bad");
endmodule // int_exec_properties
`default_nettype wire

// ---- verif/cop_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module cop_ctrl_model
  import exec_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [4:0]      cop_ctrl_rindex,
  output logic      [XLEN-1:0] cop_ctrl_rdata,
  input  wire logic            cop_ctrl_wr,
  input  wire logic [4:0]      cop_ctrl_windex,
  input  wire logic [XLEN-1:0] cop_ctrl_wdata
);
  logic [XLEN-1:0] regs [32];
  initial for (int k = 0; k < 32; k++) regs[k] = {32'h5A5A5A5A, 27'h0, k[4:0]};
  assign cop_ctrl_rdata = regs[cop_ctrl_rindex];
  always @(posedge clk) if (cop_ctrl_wr) regs[cop_ctrl_windex] <= cop_ctrl_wdata;
endmodule // cop_ctrl_model
`default_nettype wire

// ---- verif/tb_int_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_int_exec;
  import exec_pkg::*;
  typedef struct packed {logic [5:0] p; logic [4:0] idx; logic [63:0] d; logic [63:0] t;} exp_t;
  logic        clk, rst_n, instr_valid, cop_condition_bit, wb_valid, redirect_valid;
  logic        ce, ce_seen;
  logic [5:0]  held;
  logic        nullify_next, overflow_trap, unknown_instr, cop_ctrl_wr;
  logic [31:0] instr, i, r;
  logic [4:0]  cop_ctrl_rindex, wb_index, cop_ctrl_windex;
  logic [5:0]  op;
  logic [63:0] pc, first_source_reg, second_source_reg, cop_ctrl_rdata, wb_data, a;
  logic [63:0] redirect_pc, cop_ctrl_wdata;
  int          error_cnt, n_tests, seed, skip;
  exp_t        q[$];
  logic [63:0] shadow [32];
  logic [5:0]  ops [16] = '{OP_SPECIAL, OP_REGIMM, OP_BR_EQ, OP_BR_NE, OP_BR_LEZ, OP_BR_GTZ,
    OP_ADD_IMM, OP_ADD_IMM_U, OP_AND_IMM, OP_COP2, OP_BR_EQ_L, OP_BR_NE_L, OP_BR_LEZ_L,
    OP_BR_GTZ_L, OP_COP2, 6'h3F};
  logic [5:0]  fns [4] = '{FN_ADD, FN_ADD_U, FN_AND, 6'h3F};
  logic [4:0]  cps [4] = '{CP_READ_CTRL, CP_WRITE_CTRL, CP_BRANCH, CP_BRANCH};
  int_exec int_exec_inst (.clk, .rst_n, .ce, .instr_valid, .instr, .pc, .first_source_reg,
    .second_source_reg, .cop_condition_bit, .cop_ctrl_rdata, .cop_ctrl_rindex, .wb_valid,
    .wb_index, .wb_data, .redirect_valid, .redirect_pc, .nullify_next, .overflow_trap,
    .unknown_instr, .cop_ctrl_wr, .cop_ctrl_windex, .cop_ctrl_wdata);
  cop_ctrl_model cop_ctrl_model_inst (.clk, .cop_ctrl_rindex, .cop_ctrl_rdata, .cop_ctrl_wr,
    .cop_ctrl_windex, .cop_ctrl_wdata);
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [63:0] val();
    logic [1:0] v;
    v = $random(seed);
    return v == 0 ? 64'h0 : v == 1 ? 64'h7FFFFFFF : v == 2 ? 64'hFFFFFFFF80000000
      : {$random(seed), $random(seed)};
  endfunction
  // Drives one instruction and notes what the outputs must show one edge later.
  task automatic issue(logic [31:0] i, logic [63:0] a, logic [63:0] b, logic c);
    logic [5:0] op;
    logic [63:0] im, s, p;
    logic tk, lk, br, li;
    exp_t e;
    op = i[31:26];
    im = {{48{i[15]}}, i[15:0]};
    p = {$random(seed), $random(seed)} & ~64'h3;
    {e, br, li, lk, tk} = '0;
    @(negedge clk);
    {instr_valid, instr, pc, first_source_reg, second_source_reg} <= {1'b1, i, p, a, b};
    cop_condition_bit <= c;
    if (skip) skip = 0;
    else begin
      case (op)
        OP_SPECIAL, OP_ADD_IMM, OP_ADD_IMM_U: begin
          if (op != OP_SPECIAL) b = im;
          s = a[31:0] + b[31:0];
          s = {{32{s[31]}}, s[31:0]};
          if (op == OP_SPECIAL && i[5:0] == FN_AND) s = a & b;
          e = {6'h20, op == OP_SPECIAL ? i[15:11] : i[20:16], s, 64'h0};
          if ((op == OP_ADD_IMM || op == OP_SPECIAL && i[5:0] == FN_ADD) && a[31] == b[31]
              && s[31] != a[31]) e.p = 6'h04;
          if (op == OP_SPECIAL && !(i[5:0] inside {FN_ADD, FN_ADD_U, FN_AND})) e.p = 6'h01;
        end
        OP_AND_IMM: e = {6'h20, i[20:16], a & {48'h0, i[15:0]}, 64'h0};
        OP_BR_EQ, OP_BR_NE, OP_BR_EQ_L, OP_BR_NE_L:
          {br, li, tk} = {1'b1, op[4], (a == b) ^ op[0]};
        OP_BR_LEZ, OP_BR_GTZ, OP_BR_LEZ_L, OP_BR_GTZ_L:
          {br, li, tk} = {1'b1, op[4], (a[63] || a == 64'h0) ^ op[0]};
        OP_REGIMM: {br, li, lk, tk} = {1'b1, i[17], i[20], a[63] ^ i[16]};
        OP_COP2: case (i[25:21])
          CP_BRANCH: {br, li, tk} = {1'b1, i[17], c == i[16]};
          CP_WRITE_CTRL: begin
            e = {6'h02, i[15:11], b, 64'h0};
            shadow[i[15:11]] = b;
          end
          default: e = {6'h20, i[20:16], shadow[i[15:11]], 64'h0};
        endcase
        default: e.p = 6'h01;
      endcase
      if (br) begin
        e = {lk, tk, li && !tk, 3'b0, LINK_REG, p + LINK_OFFSET, p + 64'h4 + (im << 2)};
        skip = li && !tk;
      end
      if (e.p != 0) q.push_back(e);
    end
  endtask
  always @(posedge clk) ce_seen <= ce;
  always @(negedge clk) begin
    exp_t e;
    if (rst_n && !ce_seen) begin
      chk("frozen", {wb_valid, redirect_valid, nullify_next, overflow_trap, cop_ctrl_wr,
        unknown_instr}, held);
    end else if (rst_n && {wb_valid, redirect_valid, nullify_next, overflow_trap, cop_ctrl_wr,
        unknown_instr} != 0) begin
      e = q.size() > 0 ? q.pop_front() : '0;
      chk("pulses", {wb_valid, redirect_valid, nullify_next, overflow_trap, cop_ctrl_wr,
        unknown_instr}, e.p);
      if (e.p[5]) chk("wb_index", wb_index, e.idx);
      if (e.p[5]) chk("wb_data", wb_data, e.d);
      if (e.p[4]) chk("redirect_pc", redirect_pc, e.t);
      if (e.p[1]) chk("cop_ctrl_wdata", cop_ctrl_wdata, e.d);
      if (e.p[1]) chk("cop_ctrl_windex", cop_ctrl_windex, e.idx);
    end
    held = {wb_valid, redirect_valid, nullify_next, overflow_trap, cop_ctrl_wr, unknown_instr};
  end
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 20000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    seed = 32'h45CA538C;
    {rst_n, instr_valid, instr, pc, first_source_reg, second_source_reg, cop_condition_bit} = '0;
    {skip, error_cnt, n_tests} = '0;
    ce = 1;
    for (int k = 0; k < 32; k++) shadow[k] = {32'h5A5A5A5A, 27'h0, k[4:0]};
    repeat (6) @(negedge clk);
    rst_n <= 1;
    repeat (3000) begin
      r = $random(seed);
      i = $random(seed);
      op = ops[r[3:0]];
      {i[31:26], i[11], i[16]} = {op, 2'b11};
      if (op == OP_SPECIAL) i[5:0] = fns[r[5:4]];
      if (op == OP_REGIMM) i[20:16] = {r[6], 2'b0, r[8:7]};
      if (op == OP_COP2) i[25:21] = cps[r[10:9]];
      if (op == OP_COP2 && i[25:21] == CP_BRANCH) i[20:16] = {3'b0, r[8:7]};
      a = val();
      issue(i, a, r[11] ? a : val(), r[12]);
      if (!skip && (r[15:13] == 0 || op == OP_COP2 && i[25:21] == CP_WRITE_CTRL)) begin
        @(negedge clk);
        instr_valid <= 0;
      end
      if (!skip && r[18:16] == 0) begin
        @(negedge clk);
        {ce, instr_valid} <= 2'b00;
        repeat (2) @(negedge clk);
        ce <= 1;
      end
    end
    repeat (3) @(negedge clk);
    chk("leftover", q.size(), 0);
    give_verdict();
  end
endmodule // tb_int_exec
bind int_exec int_exec_properties int_exec_properties_inst (.clk, .rst_n, .ce, .instr_valid,
  .instr, .pc, .first_source_reg, .second_source_reg, .cop_condition_bit, .wb_valid, .wb_index,
  .wb_data, .redirect_valid, .nullify_next, .cop_ctrl_wr, .cop_ctrl_windex, .cop_ctrl_wdata);
`default_nettype wire
